// ===== verilog/pin_change_pkg.sv
// Package with register map, field layout and carrier types of the pin change interrupt block.
package pin_change_pkg;

    localparam int unsigned PIN_COUNT        = 8;
    localparam int unsigned ADDR_W           = 4;

    // ========================================================================
    // Register byte offsets.
    // ========================================================================
    localparam logic [ADDR_W-1:0] OFS_RISE_EN = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FALL_EN = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_FLAGS   = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'hc;

    // ========================================================================
    // Field positions and reset values.
    // ========================================================================
    localparam int unsigned CTRL_MASTER_EN_BIT = 0;
    localparam int unsigned CTRL_SUMMARY_BIT   = 1;
    localparam logic [7:0]  RISE_EN_RST        = 8'h00;
    localparam logic [7:0]  FALL_EN_RST        = 8'h00;
    localparam logic [7:0]  FLAGS_RST          = 8'h00;
    localparam logic        MASTER_EN_RST      = 1'b0;

    // ========================================================================
    // AHB-Lite encodings.
    // ========================================================================
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic        HRESP_OKAY    = 1'b0;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

    // Software write request for the flag register.
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } flag_write_s;

    // Per-pin edge enables.
    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
    } edge_enable_s;

endpackage

// ===== verilog/pin_edge_detect.sv
// Synchroniser and enabled edge detector for the port pins.
`timescale 1ns/10ps
`default_nettype none
module pin_edge_detect
    import pin_change_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             hclk,     // System clock.
    input  wire logic             hresetn,  // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] pins,     // Raw port pin levels.
    input  wire edge_enable_s     en,       // Rising and falling enables.
    output logic      [WIDTH-1:0] hit       // Enabled edge seen this cycle.
);

    logic [WIDTH-1:0] sync1_q, sync1_d;
    logic [WIDTH-1:0] sync2_q, sync2_d;
    logic [WIDTH-1:0] prev_q, prev_d;
    logic [2:0]       primed_q, primed_d;
    logic [WIDTH-1:0] rise, fall;

    // ========================================================================
    // Two-stage synchroniser and previous-sample register.
    // ========================================================================
    always_comb begin
        sync1_d = pins;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
        // Edges count only once the previous-sample register holds a real pin level,
        // so a pin that sits high through reset does not fake a rising edge.
        primed_d = {primed_q[1:0], 1'b1};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
            primed_q <= 3'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
            primed_q <= primed_d;
        end
    end

    // Edges qualify only through their own enable bit.
    always_comb begin
        rise = sync2_q & ~prev_q;
        fall = ~sync2_q & prev_q;
        hit  = ((rise & en.rise[WIDTH-1:0]) | (fall & en.fall[WIDTH-1:0])) & {WIDTH{primed_q[2]}};
    end

endmodule
`default_nettype wire

// ===== verilog/pin_change_irq.sv
// Pin edge change interrupt block with AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pin_change_irq
    import pin_change_pkg::*;
#(
    parameter int unsigned PINS = PIN_COUNT
) (
    input  wire logic            hclk,       // System clock, 125 MHz.
    input  wire logic            hresetn,    // Asynchronous reset, active low.
    input  wire logic            hsel,       // Slave select.
    input  wire logic [31:0]     haddr,      // Byte address.
    input  wire logic [1:0]      htrans,     // Transfer type.
    input  wire logic            hwrite,     // Write when high.
    input  wire logic [2:0]      hsize,      // Transfer size.
    input  wire logic [31:0]     hwdata,     // Write data.
    input  wire logic            hready,     // Bus ready in.
    output logic      [31:0]     hrdata,     // Read data.
    output logic                 hreadyout,  // Slave ready.
    output logic                 hresp,      // Response, always OKAY.
    input  wire logic [PINS-1:0] port_pin,   // Port pin levels.
    output logic                 irq,        // Interrupt request, level.
    output logic                 wake        // Wake from sleep, level.
);

    logic [7:0]        rise_en_q, rise_en_d;
    logic [7:0]        fall_en_q, fall_en_d;
    logic [PINS-1:0]   flags_q, flags_d;
    logic              master_en_q, master_en_d;
    logic              irq_q, irq_d;
    logic              wake_q, wake_d;
    logic              wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [PINS-1:0]   hit;
    logic              take;
    flag_write_s       fw;
    edge_enable_s      en;

    // Reads the values that the registers take at this edge, so a read right after a write sees the new data.
    function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFS_RISE_EN: v[7:0] = rise_en_d;
            OFS_FALL_EN: v[7:0] = fall_en_d;
            OFS_FLAGS:   v[PINS-1:0] = flags_d;
            OFS_CTRL: begin
                v[CTRL_MASTER_EN_BIT] = master_en_d;
                v[CTRL_SUMMARY_BIT]   = |flags_d;
            end
            default:     v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ========================================================================
    // Edge detection.
    // ========================================================================
    always_comb begin
        en.rise = rise_en_q;
        en.fall = fall_en_q;
    end

    pin_edge_detect #(
        .WIDTH (PINS)
    ) i_pin_edge_detect (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    (port_pin),
        .en      (en),
        .hit     (hit)
    );

    // ========================================================================
    // AHB-Lite slave: zero wait states, write data applied in data phase.
    // ========================================================================
    always_comb begin
        take      = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
        wr_pend_d = take && hwrite;
        addr_d    = take ? haddr[ADDR_W-1:0] : addr_q;
        fw.wr     = wr_pend_q && (addr_q == OFS_FLAGS);
        fw.data   = hwdata[7:0];
    end

    // ========================================================================
    // Register file and flags.
    // ========================================================================
    always_comb begin
        rise_en_d   = rise_en_q;
        fall_en_d   = fall_en_q;
        master_en_d = master_en_q;
        flags_d     = flags_q;
        if (wr_pend_q && addr_q == OFS_RISE_EN) begin
            rise_en_d = hwdata[7:0];
        end
        if (wr_pend_q && addr_q == OFS_FALL_EN) begin
            fall_en_d = hwdata[7:0];
        end
        if (wr_pend_q && addr_q == OFS_CTRL) begin
            master_en_d = hwdata[CTRL_MASTER_EN_BIT];
        end
        if (fw.wr) begin
            flags_d = fw.data[PINS-1:0];
        end
        flags_d = flags_d | hit;
        irq_d   = master_en_d && (|flags_d);
        wake_d  = master_en_d && (|flags_d);
    end

    // Read data is captured at the address-phase edge and stands for the data phase.
    always_comb begin
        rdata_d = (take && !hwrite) ? read_mux(haddr[ADDR_W-1:0]) : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_en_q   <= RISE_EN_RST;
            fall_en_q   <= FALL_EN_RST;
            flags_q     <= FLAGS_RST[PINS-1:0];
            master_en_q <= MASTER_EN_RST;
            irq_q       <= 1'b0;
            wake_q      <= 1'b0;
            wr_pend_q   <= 1'b0;
            addr_q      <= '0;
            rdata_q     <= 32'h0000_0000;
        end else begin
            rise_en_q   <= rise_en_d;
            fall_en_q   <= fall_en_d;
            flags_q     <= flags_d;
            master_en_q <= master_en_d;
            irq_q       <= irq_d;
            wake_q      <= wake_d;
            wr_pend_q   <= wr_pend_d;
            addr_q      <= addr_d;
            rdata_q     <= rdata_d;
        end
    end

    always_comb begin
        hrdata    = rdata_q;
        hreadyout = 1'b1;
        hresp     = HRESP_OKAY;
        irq       = irq_q;
        wake      = wake_q;
    end

    // ========================================================================
    // Assertions.
    // ========================================================================
    property p_rise_sets;
        @(posedge hclk) disable iff (!hresetn)
        (hit != '0) |=> ((flags_q & $past(hit)) == $past(hit));
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("Enabled edge did not set flag.");

    property p_fall_path;
        @(posedge hclk) disable iff (!hresetn)
        $fell(i_pin_edge_detect.sync2_q[0]) && fall_en_q[0] |-> hit[0];
    endproperty
    a_fall_path: assert property (p_fall_path) else $error("Falling edge not detected.");

    property p_no_enable;
        @(posedge hclk) disable iff (!hresetn)
        (hit & ~(rise_en_q[PINS-1:0] | fall_en_q[PINS-1:0])) == '0;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("Disabled pin flagged an edge.");

    property p_set_cause;
        @(posedge hclk) disable iff (!hresetn)
        !fw.wr |=> (flags_q & ~$past(flags_q) & ~$past(hit)) == '0;
    endproperty
    a_set_cause: assert property (p_set_cause) else $error("Flag set without enabled edge.");

    property p_sw_clear;
        @(posedge hclk) disable iff (!hresetn)
        fw.wr && hit == '0 |=> flags_q == $past(fw.data[PINS-1:0]);
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("Software write not applied.");

    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        fw.wr && hit != '0 |=> (flags_q & $past(hit)) == $past(hit);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Edge lost during clear.");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        irq == (master_en_q && (flags_q != '0));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Request without master enable.");

    property p_wake_flags;
        @(posedge hclk) disable iff (!hresetn)
        $rose(wake) |-> (flags_q != '0);
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("Wake before flags updated.");

    property p_summary;
        @(posedge hclk) disable iff (!hresetn)
        take && !hwrite && haddr[ADDR_W-1:0] == OFS_CTRL |=> hrdata[CTRL_SUMMARY_BIT] == (|flags_q);
    endproperty
    a_summary: assert property (p_summary) else $error("Summary flag wrong.");

    c_irq:   cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    c_race:  cover property (@(posedge hclk) disable iff (!hresetn) fw.wr && hit != '0);
    c_clear: cover property (@(posedge hclk) disable iff (!hresetn) $fell(|flags_q));
    c_sum_read: cover property (@(posedge hclk) disable iff (!hresetn) take && !hwrite && haddr[ADDR_W-1:0] == OFS_CTRL);

endmodule
`default_nettype wire

// ===== testbench/pin_source.sv
// Model of the external signals that drive the port pins.
`timescale 1ns/10ps
`default_nettype none
module pin_source (
    input  wire logic       hclk,       // System clock.
    input  wire logic [7:0] level_req,  // Pin levels asked for by the bench.
    output logic      [7:0] port_pin    // Pin levels seen by the block.
);
    // Pins move on the falling edge, so they are asynchronous to the sampling edge.
    always_ff @(negedge hclk) begin
        port_pin <= level_req;
    end
endmodule
`default_nettype wire

// ===== testbench/pin_edge_change_interrupt_tb.sv
// Self-checking bench for the pin change interrupt block.
`timescale 1ns/10ps
`default_nettype none
module pin_edge_change_interrupt_tb
    import pin_change_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, wake;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  level_req, port_pin;
    int          fail_count, comparisons;
    logic [7:0]  tab_r [3] = '{8'h55, 8'haa, 8'h0f};
    logic [7:0]  tab_f [3] = '{8'haa, 8'h55, 8'h30};
    logic [7:0]  tab_x [3] = '{8'hff, 8'hff, 8'h3f};

    pin_change_irq i_pin_change_irq (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_pin(port_pin), .irq(irq),
        .wake(wake));
    pin_source i_pin_source (.hclk(hclk), .level_req(level_req), .port_pin(port_pin));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ========================================================================
    // Reporting and bus tasks.
    // ========================================================================
    task close_out;
        $display("Mismatches: %0d, comparisons: %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t register read %h, expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t output bit %b, expected %b", $time, got, exp);
        end
    endtask

    // Waits for the next edge with hready high, never longer than the bound.
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t bus wait timed out", $time);
            close_out;
        end
    endtask

    task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= 32'(a);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        wait_ready;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_word(rd, e);
    endtask

    // ========================================================================
    // Main sequence.
    // ========================================================================
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        level_req = 8'h00;
        fail_count = 0;
        comparisons = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(OFS_RISE_EN, 32'h0);
        rchk(OFS_FALL_EN, 32'h0);
        rchk(OFS_FLAGS, 32'h0);
        rchk(OFS_CTRL, 32'h0);
        chk_bit(hresp, HRESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_RISE_EN, {24'h0, tab_r[i]});
            wr(OFS_FALL_EN, {24'h0, tab_f[i]});
            rchk(OFS_RISE_EN, {24'h0, tab_r[i]});
            rchk(OFS_FALL_EN, {24'h0, tab_f[i]});
            wr(OFS_FLAGS, 32'h0);
            level_req <= 8'hff;
            repeat (6) @(posedge hclk);
            rchk(OFS_FLAGS, {24'h0, tab_r[i]});
            level_req <= 8'h00;
            repeat (6) @(posedge hclk);
            rchk(OFS_FLAGS, {24'h0, tab_x[i]});
            rchk(OFS_CTRL, 32'h2);
            chk_bit(irq, 1'b0);
        end
        wr(OFS_FLAGS, 32'h81);
        rchk(OFS_FLAGS, 32'h81);
        wr(OFS_FLAGS, 32'h0);
        rchk(OFS_FLAGS, 32'h0);
        rchk(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        level_req <= 8'h01;
        repeat (6) @(posedge hclk);
        chk_bit(irq, 1'b1);
        chk_bit(wake, 1'b1);
        rchk(OFS_CTRL, 32'h3);
        // The clearing write lands on the edge that sets the flag of pin 1.
        level_req <= 8'h03;
        repeat (1) @(posedge hclk);
        wr(OFS_FLAGS, 32'h0);
        rchk(OFS_FLAGS, 32'h2);
        wr(OFS_FLAGS, 32'h0);
        repeat (2) @(posedge hclk);
        chk_bit(irq, 1'b0);
        chk_bit(wake, 1'b0);
        wr(OFS_CTRL, 32'h0);
        level_req <= 8'h07;
        repeat (6) @(posedge hclk);
        rchk(OFS_FLAGS, 32'h4);
        chk_bit(irq, 1'b0);
        close_out;
    end
endmodule
`default_nettype wire
